// ==== logic/wit_pkg.sv ====
package wit_pkg;
    // -----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // -----------------------------------------------------------------
    localparam logic [7:0] WIT_OFS_CONTROL = 8'h00;
    localparam logic [7:0] WIT_OFS_FEED = 8'h04;
    localparam logic [7:0] WIT_OFS_INT_STATUS = 8'h08;
    localparam logic [7:0] WIT_OFS_INT_CLEAR = 8'h0C;
    localparam logic [7:0] WIT_OFS_INT_ENABLE = 8'h10;

    // -----------------------------------------------------------------
    // watchdog_control fields
    // -----------------------------------------------------------------
    localparam int WIT_BIT_OVERFLOW = 5;
    localparam int WIT_BIT_RUN = 4;
    localparam int WIT_BIT_CLKSEL = 3;
    localparam int WIT_RATE_LSB = 0;
    localparam logic [7:0] WIT_CTRL_RESET = 8'h00;
    localparam logic [7:0] WIT_CTRL_WDOG_RESET = 8'h10;

    // interrupt status bits
    localparam int WIT_INT_TIMEOUT = 0;
    localparam int WIT_INT_WDOG_RST = 1;
    localparam int WIT_INT_W = 2;

    // feed key bytes
    localparam logic [7:0] WIT_FEED_KEY1 = 8'h1E;
    localparam logic [7:0] WIT_FEED_KEY2 = 8'hE1;

    // -----------------------------------------------------------------
    // counts and timing
    // -----------------------------------------------------------------
    localparam int WIT_CNT_W = 21;
    localparam logic [20:0] WIT_BASE_TICKS = 21'h002000;
    localparam int WIT_CLK_PERIOD_NS = 8;
    localparam int WIT_RST_PULSE_NS = 1000;
    localparam int WIT_RST_PULSE_CYC_I = (WIT_RST_PULSE_NS / WIT_CLK_PERIOD_NS) < 1 ? 1 :
                                         (WIT_RST_PULSE_NS / WIT_CLK_PERIOD_NS);
    localparam logic [7:0] WIT_RST_PULSE_CYC = 8'(WIT_RST_PULSE_CYC_I);

    // pin input order for the synchroniser bank
    localparam int WIT_PIN_OSC = 0;
    localparam int WIT_PIN_OTHER_RST = 1;
    localparam int WIT_PIN_PWRDN = 2;
    localparam int WIT_PIN_OSC_STABLE = 3;
    localparam int WIT_PIN_CPU_CLK = 4;
    localparam int WIT_PIN_N = 5;

    // reset sequencer states
    typedef enum logic [2:0] {
        WIT_ST_IDLE = 3'b001,
        WIT_ST_PULSE = 3'b010,
        WIT_ST_WAIT_OSC = 3'b100
    } wit_state_t;
endpackage : wit_pkg

// ==== logic/wit_pin_sync.sv ====
`timescale 1ns/1ns
// three-stage pin synchroniser with agreement filter and rise pulse
module wit_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;
    logic rise_ff;
    wire agree = (s2_ff == s3_ff);

    // -----------------------------------------------------------------
    // sampling chain; only the second stage reads the first
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            level_ff <= 1'b0;
            rise_ff <= 1'b0;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            level_ff <= agree ? s3_ff : level_ff;
            rise_ff <= agree & s3_ff & ~level_ff;
        end
    end

    assign level = level_ff;
    assign rise = rise_ff;
endmodule : wit_pin_sync

// ==== logic/wit_watchdog.sv ====
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ns
// How it works
// (RULE1) with watchdog enabled the counter ticks only from the independent oscillator.
// (RULE2) enabled watchdog must be fed; nothing can stop it.
// (RULE3) with watchdog off the counter is an interval timer raising an interrupt.
// (RULE4) eight timeout selections, nominally 16 ms up to 2.1 s.
// (RULE5) when enabled, control register takes one write only after start-up.
// (RULE6) software feeds then sets rate within 10 ms of start-up safely.
// (RULE7) enabled watchdog still expires and resets if the cpu clock stops.
// (RULE8) enabled watchdog held idle while another chip reset is active.
// (RULE9) a feed needs 1Eh then E1h written to the feed register.
// (RULE10) other activity may come between the two feed writes.
// (RULE11) wrong feed bytes do nothing; expiry time stays unchanged.
// (RULE12) watchdog timeout asserts internal reset for about one microsecond.
// (RULE13) if cpu clock runs, execution restarts right after the reset.
// (RULE14) from power-down, reset restarts oscillator and waits until it is stable.
// (RULE15) each higher rate code doubles the oscillator clocks before timeout.
module wit_watchdog (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdog_enable_cfg,
    input wire logic wdog_osc_pin,
    input wire logic other_reset_pin,
    input wire logic power_down_pin,
    input wire logic osc_stable_pin,
    input wire logic cpu_clk_running_pin,
    output logic wdog_reset,
    output logic cpu_hold,
    output logic osc_start,
    output logic irq
);
    import wit_pkg::*;

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [WIT_PIN_N-1:0] pin_raw;
    logic [WIT_PIN_N-1:0] pin_lvl;
    logic [WIT_PIN_N-1:0] pin_rise;
    assign pin_raw = {cpu_clk_running_pin, osc_stable_pin, power_down_pin, other_reset_pin, wdog_osc_pin};

    genvar gi;
    generate
        for (gi = 0; gi < WIT_PIN_N; gi = gi + 1) begin : g_sync
            wit_pin_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .pin(pin_raw[gi]),
                .level(pin_lvl[gi]),
                .rise(pin_rise[gi])
            );
        end
    endgenerate

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic cfg_taken_ff;
    logic wd_mode_ff;
    logic [7:0] ctrl_ff;
    logic ctrl_locked_ff;
    logic key1_seen_ff;
    logic [WIT_CNT_W-1:0] count_ff;
    logic [WIT_INT_W-1:0] int_status_ff;
    logic [WIT_INT_W-1:0] int_enable_ff;
    wit_state_t state_ff;
    logic [7:0] pulse_cnt_ff;
    logic from_pwrdn_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic wdog_reset_ff;
    logic cpu_hold_ff;
    logic osc_start_ff;
    logic irq_ff;

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    wire setup = psel & ~penable;
    wire wr_take = psel & penable & pready_ff & pwrite;
    wire hit_ctrl = (paddr == WIT_OFS_CONTROL);
    wire hit_feed = (paddr == WIT_OFS_FEED);
    wire hit_stat = (paddr == WIT_OFS_INT_STATUS);
    wire hit_clr = (paddr == WIT_OFS_INT_CLEAR);
    wire hit_en = (paddr == WIT_OFS_INT_ENABLE);
    wire mapped = hit_ctrl | hit_feed | hit_stat | hit_clr | hit_en;
    wire wr_ctrl = wr_take & hit_ctrl;
    wire wr_feed = wr_take & hit_feed;
    wire wr_clr = wr_take & hit_clr;
    wire wr_en = wr_take & hit_en;

    // read mux; feed and clear registers read as zero
    wire [31:0] rd_val = hit_ctrl ? {24'h000000, ctrl_ff} :
                         hit_stat ? {30'h00000000, int_status_ff} :
                         hit_en ? {30'h00000000, int_enable_ff} : 32'h00000000;

    // -----------------------------------------------------------------
    // counter control
    // -----------------------------------------------------------------
    // once enabled as a watchdog the run bit is forced on and the
    // clock select forced to the rc oscillator
    wire run = wd_mode_ff | ctrl_ff[WIT_BIT_RUN]; // [RULE2]
    wire use_pclk = ~wd_mode_ff & ctrl_ff[WIT_BIT_CLKSEL]; // [RULE1]
    // the oscillator pin is independent of the cpu clock, so a dead cpu
    // oscillator still leaves ticks arriving here
    wire tick = use_pclk | pin_rise[WIT_PIN_OSC]; // [RULE1] [RULE7]
    wire held = wd_mode_ff & pin_lvl[WIT_PIN_OTHER_RST]; // [RULE8]
    wire [2:0] rate = ctrl_ff[WIT_RATE_LSB+2:WIT_RATE_LSB];
    wire [WIT_CNT_W-1:0] terminal = WIT_BASE_TICKS << rate; // [RULE4] [RULE15]
    wire expire = cfg_taken_ff & run & ~held & tick & (count_ff == terminal - 21'h000001);
    wire feed_ok = wr_feed & key1_seen_ff & (pwdata[7:0] == WIT_FEED_KEY2); // [RULE9]
    wire wd_expire = expire & wd_mode_ff;
    wire iv_expire = expire & ~wd_mode_ff; // [RULE3]
    // control write allowed always in timer mode, once in watchdog mode
    wire ctrl_wr_ok = wr_ctrl & (~wd_mode_ff | ~ctrl_locked_ff); // [RULE5]

    wire [WIT_CNT_W-1:0] nxt_count = (held | feed_ok | expire | ~run) ? '0 : // [RULE11]
                                     (cfg_taken_ff & tick) ? count_ff + 21'h000001 : count_ff;

    // -----------------------------------------------------------------
    // strap capture and apb answer
    // -----------------------------------------------------------------
    // the configuration bit is caught once, the first edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_taken_ff <= 1'b0;
            wd_mode_ff <= 1'b0;
        end else if (!cfg_taken_ff) begin
            cfg_taken_ff <= 1'b1;
            wd_mode_ff <= wdog_enable_cfg;
        end
    end

    // zero wait states: answer in the access cycle after every setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~mapped;
            prdata_ff <= (setup & ~pwrite) ? rd_val : prdata_ff;
        end
    end

    // -----------------------------------------------------------------
    // control register, feed key and counter
    // -----------------------------------------------------------------
    wire [7:0] ctrl_wval = {2'b00, ctrl_ff[WIT_BIT_OVERFLOW] & pwdata[WIT_BIT_OVERFLOW], pwdata[4:0]};
    wire [7:0] ctrl_upd = ctrl_wr_ok ? ctrl_wval : ctrl_ff;
    wire [7:0] ctrl_forced = wd_mode_ff ? (ctrl_upd | 8'h10) & 8'hF7 : ctrl_upd; // [RULE2]
    // overflow set wins over a software clear in the same cycle
    wire [7:0] nxt_ctrl = expire ? (ctrl_forced | 8'h20) : ctrl_forced;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= WIT_CTRL_RESET;
        end else if (cfg_taken_ff) begin
            ctrl_ff <= nxt_ctrl;
        end else begin
            ctrl_ff <= wdog_enable_cfg ? WIT_CTRL_WDOG_RESET : WIT_CTRL_RESET; // [RULE6]
        end
    end

    // lock closes after the first control write in watchdog mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_locked_ff <= 1'b0;
        end else if (wr_ctrl & wd_mode_ff) begin
            ctrl_locked_ff <= 1'b1; // [RULE5]
        end
    end

    // key state survives unrelated bus traffic; only feed writes move it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key1_seen_ff <= 1'b0;
        end else if (wr_feed) begin
            key1_seen_ff <= (pwdata[7:0] == WIT_FEED_KEY1); // [RULE9] [RULE10] [RULE11]
        end
    end

    // the rate starts at the shortest setting, so a feed within 10 ms is safe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count; // [RULE6] [RULE8]
        end
    end

    // -----------------------------------------------------------------
    // interrupt status, enable, output
    // -----------------------------------------------------------------
    wire [WIT_INT_W-1:0] int_set = {wd_expire, iv_expire}; // [RULE3]
    wire [WIT_INT_W-1:0] int_clr = wr_clr ? pwdata[WIT_INT_W-1:0] : '0;
    wire [WIT_INT_W-1:0] nxt_int_status = (int_status_ff & ~int_clr) | int_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_ff <= '0;
            int_enable_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            int_status_ff <= nxt_int_status;
            int_enable_ff <= wr_en ? pwdata[WIT_INT_W-1:0] : int_enable_ff;
            irq_ff <= |(nxt_int_status & (wr_en ? pwdata[WIT_INT_W-1:0] : int_enable_ff));
        end
    end

    // -----------------------------------------------------------------
    // reset sequencer
    // -----------------------------------------------------------------
    wit_state_t nxt_state;
    logic [7:0] nxt_pulse_cnt;
    logic nxt_from_pwrdn;

    always_comb begin
        nxt_state = state_ff;
        nxt_pulse_cnt = pulse_cnt_ff;
        nxt_from_pwrdn = from_pwrdn_ff;
        case (state_ff)
            WIT_ST_IDLE: begin
                if (wd_expire) begin
                    nxt_state = WIT_ST_PULSE; // [RULE2] [RULE7]
                    nxt_pulse_cnt = WIT_RST_PULSE_CYC;
                    nxt_from_pwrdn = pin_lvl[WIT_PIN_PWRDN] | ~pin_lvl[WIT_PIN_CPU_CLK];
                end
            end
            WIT_ST_PULSE: begin
                nxt_pulse_cnt = pulse_cnt_ff - 8'h01;
                if (pulse_cnt_ff == 8'h01) begin
                    // running cpu clock outside power-down goes straight back to work
                    nxt_state = from_pwrdn_ff ? WIT_ST_WAIT_OSC : WIT_ST_IDLE; // [RULE12] [RULE13]
                end
            end
            WIT_ST_WAIT_OSC: begin
                if (pin_lvl[WIT_PIN_OSC_STABLE]) begin
                    nxt_state = WIT_ST_IDLE; // [RULE14]
                    nxt_from_pwrdn = 1'b0;
                end
            end
            default: begin
                nxt_state = WIT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= WIT_ST_IDLE;
            pulse_cnt_ff <= 8'h00;
            from_pwrdn_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pulse_cnt_ff <= nxt_pulse_cnt;
            from_pwrdn_ff <= nxt_from_pwrdn;
        end
    end

    // outputs registered from the next state so they line up with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_reset_ff <= 1'b0;
            cpu_hold_ff <= 1'b0;
            osc_start_ff <= 1'b0;
        end else begin
            wdog_reset_ff <= (nxt_state == WIT_ST_PULSE); // [RULE12]
            cpu_hold_ff <= (nxt_state != WIT_ST_IDLE); // [RULE14]
            osc_start_ff <= (nxt_state == WIT_ST_WAIT_OSC); // [RULE14]
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign wdog_reset = wdog_reset_ff;
    assign cpu_hold = cpu_hold_ff;
    assign osc_start = osc_start_ff;
    assign irq = irq_ff;
endmodule : wit_watchdog

// ==== sim/wit_watchdog_properties.sv ====
`timescale 1ns/1ns
module wit_watchdog_checker
    import wit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_clk_running_pin,
    input wire logic power_down_pin,
    input wire logic wdog_reset,
    input wire logic cpu_hold,
    input wire logic osc_start,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic mapped;
    logic [7:0] pulse_cnt_ff;
    assign mapped = paddr inside {WIT_OFS_CONTROL, WIT_OFS_FEED, WIT_OFS_INT_STATUS, WIT_OFS_INT_CLEAR,
                                  WIT_OFS_INT_ENABLE};
    // counts reset pulse length; cleared whenever the pulse is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt_ff <= 8'h00;
        end else begin
            pulse_cnt_ff <= wdog_reset ? pulse_cnt_ff + 8'h01 : 8'h00;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_zero_wait; s_setup |=> pready; endproperty
    property p_one_cycle; pready |=> !pready; endproperty
    property p_err_map; s_done |-> (pslverr == !mapped); endproperty
    property p_unmapped_zero; s_done ##0 (!mapped && !pwrite) |-> prdata == 32'h0; endproperty
    property p_pulse_len; $fell(wdog_reset) |-> pulse_cnt_ff == WIT_RST_PULSE_CYC; endproperty
    property p_hold_with; wdog_reset |-> cpu_hold; endproperty
    property p_hold_start; $rose(wdog_reset) |-> $rose(cpu_hold); endproperty
    property p_osc_wait; osc_start |-> cpu_hold && !wdog_reset; endproperty
    property p_quick_release;
        $fell(wdog_reset) && cpu_clk_running_pin && !power_down_pin |-> ##[0:1] !cpu_hold;
    endproperty
    property p_irq_mask;
        s_done ##0 (pwrite && paddr == WIT_OFS_INT_ENABLE && pwdata[1:0] == 2'b00) |=> ##[0:1] !irq;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("pready missing after setup");
    a_one_cycle: assert property (p_one_cycle) else $error("pready held too long");
    a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
    a_hold_with: assert property (p_hold_with) else $error("cpu_hold low during reset");
    a_hold_start: assert property (p_hold_start) else $error("cpu_hold not starting with reset");
    a_osc_wait: assert property (p_osc_wait) else $error("osc_start outside hold");
    a_quick_release: assert property (p_quick_release) else $error("cpu_hold not released");
    a_irq_mask: assert property (p_irq_mask) else $error("irq stays up when masked");
endmodule : wit_watchdog_checker

bind wit_watchdog wit_watchdog_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_clk_running_pin(cpu_clk_running_pin),
    .power_down_pin(power_down_pin), .wdog_reset(wdog_reset), .cpu_hold(cpu_hold),
    .osc_start(osc_start), .irq(irq));

// ==== sim/wit_watchdog_bench.sv ====
`timescale 1ns/1ns
module wit_watchdog_bench;
    import wit_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr_ff = 32'h000158AA;
    logic cfg = 1'b1, osc = 1'b0, pready, pslverr, wdog_reset, cpu_hold, osc_start, irq;
    logic orst = 1'b0, pdn = 1'b0, ostab = 1'b1, cpuclk = 1'b1;
    int miscompares = 0, n_tests = 0, ticks = 0, ocnt = 0, hi;
    always #4 pclk = ~pclk;
    // watchdog oscillator: one tick per 4 pclk, the fastest the two-sample pin filter still sees
    always @(posedge pclk) begin
        ocnt <= (ocnt == 1) ? 0 : ocnt + 1;
        if (ocnt == 1) osc <= ~osc;
        if (ocnt == 1 && !osc) ticks <= ticks + 1;
    end
    wit_watchdog dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdog_enable_cfg(cfg), .wdog_osc_pin(osc), .other_reset_pin(orst), .power_down_pin(pdn),
        .osc_stable_pin(ostab), .cpu_clk_running_pin(cpuclk), .wdog_reset(wdog_reset),
        .cpu_hold(cpu_hold), .osc_start(osc_start), .irq(irq));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        lfsr_ff = {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
        return lfsr_ff;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one apb transfer; the leading edge keeps strobes from being set twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 1, 0);
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask : rdchk
    // waits for the reset pulse or the interrupt, counting cycles in hi
    task automatic waitr(input int lim);
        hi = 0;
        while ((wdog_reset | irq) !== 1'b1 && hi < lim) begin
            @(posedge pclk);
            hi++;
        end
    endtask : waitr
    task automatic rst(input logic c);
        presetn <= 1'b0;
        cfg <= c;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : rst
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #(8 * 95000);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] a;
        int t0, t1;
        rst(1'b1);
        rdchk(WIT_OFS_CONTROL, 32'h10, "control wdog");
        apb(1'b1, WIT_OFS_FEED, 32'h1E);
        rdchk(WIT_OFS_INT_ENABLE, 32'h0, "enable");
        apb(1'b1, WIT_OFS_FEED, 32'hE1);
        t0 = ticks;
        apb(1'b1, WIT_OFS_CONTROL, 32'h00);
        apb(1'b1, WIT_OFS_CONTROL, 32'h0F);
        rdchk(WIT_OFS_CONTROL, 32'h10, "control once");
        // unmapped places answer with an error and zero data
        repeat (4) begin
            a = 8'h14 + 8'(4 * (rnd() % 59));
            rdchk(a, 32'h0, "unmapped read");
            chk("slverr", 1, err);
        end
        while (ticks - t0 < 4000) @(posedge pclk);
        // broken feed: second byte never equals the key, then a lone key2
        apb(1'b1, WIT_OFS_FEED, 32'h1E);
        // even and with bit 7 set, so the junk byte can be neither key
        apb(1'b1, WIT_OFS_FEED, (rnd() & 32'h7E) | 32'h80);
        apb(1'b1, WIT_OFS_FEED, 32'hE1);
        waitr(60000);
        chk("expiry tick", 1, 32'(ticks - t0 >= 8190 && ticks - t0 <= 8194));
        chk("cpu_hold", 1, cpu_hold);
        hi = 0;
        while (wdog_reset === 1'b1 && hi < 300) begin
            @(posedge pclk);
            hi++;
        end
        chk("pulse", 125, hi);
        repeat (2) @(posedge pclk);
        chk("hold end", 0, cpu_hold);
        rdchk(WIT_OFS_CONTROL, 32'h30, "overflow");
        rdchk(WIT_OFS_INT_STATUS, 32'h2, "wdog status");
        // another reset source holds the count at zero; the next expiry then finds the chip powered down
        orst <= 1'b1;
        repeat (50) @(posedge pclk);
        orst <= 1'b0;
        pdn <= 1'b1;
        cpuclk <= 1'b0;
        ostab <= 1'b0;
        t1 = ticks;
        waitr(40000);
        chk("held restart", 1, 32'(ticks - t1 >= 8190 && ticks - t1 <= 8196));
        repeat (134) @(posedge pclk);
        chk("osc_start", 1, osc_start);
        chk("hold in wait", 1, cpu_hold);
        ostab <= 1'b1;
        pdn <= 1'b0;
        cpuclk <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("osc_start end", 0, osc_start);
        chk("hold released", 0, cpu_hold);
        rst(1'b0);
        rdchk(WIT_OFS_CONTROL, 32'h00, "control timer");
        apb(1'b1, WIT_OFS_INT_ENABLE, 32'h1);
        for (int r = 0; r < 2; r++) begin
            apb(1'b1, WIT_OFS_CONTROL, 32'h00);
            apb(1'b1, WIT_OFS_CONTROL, 32'h18 | r);
            waitr(40000);
            chk("interval", 1, 32'(hi >= (8192 << r) && hi <= (8192 << r) + 4));
            rdchk(WIT_OFS_INT_STATUS, 32'h1, "timeout status");
            apb(1'b1, WIT_OFS_INT_ENABLE, 32'h0);
            repeat (2) @(posedge pclk);
            chk("irq masked", 0, irq);
            apb(1'b1, WIT_OFS_INT_ENABLE, 32'h1);
            repeat (2) @(posedge pclk);
            chk("irq again", 1, irq);
            apb(1'b1, WIT_OFS_INT_CLEAR, 32'h1);
            rdchk(WIT_OFS_INT_STATUS, 32'h0, "cleared");
            chk("irq clear", 0, irq);
            chk("no reset", 0, wdog_reset);
        end
        tally_and_finish();
    end
endmodule : wit_watchdog_bench
